/* File: serial_in_parallel_out_latch.sv */
// Serial-in shift stage feeding a storage latch with three-state parallel outputs.
`timescale 1ns/100ps

module serial_in_parallel_out_latch (
    // System clock and synchronous reset.
    input  wire logic                            clk,
    input  wire logic                            srst,
    // Host pins, asynchronous to clk.
    input  wire logic                            serialIn,
    input  wire logic                            shiftClock,
    input  wire logic                            shiftClearN,
    input  wire logic                            storageClock,
    input  wire logic                            outputEnableN,
    // Parallel outputs with their enable, low while driving.
    output logic      [sipo_pkg::WORD_WIDTH-1:0] parallelOut,
    output logic                                 parallelOutEnN,
    // Serial cascade output, never three-stated.
    output logic                                 cascadeOut,
    // Latch-side flow control and capture status.
    input  wire logic                            latchReady,
    output logic                                 captureReady,
    output logic                                 latchUpdated
);

    // Synchronised pin levels.
    wire [sipo_pkg::PIN_COUNT-1:0]  pinRaw;
    wire [sipo_pkg::PIN_COUNT-1:0]  pinSync;
    wire                            serSync;
    wire                            shiftClkSync;
    wire                            clearNSync;
    wire                            storeClkSync;
    wire                            oeNSync;

    // Edge detection on the two host clocks.
    logic                           shiftPrev_q;
    logic                           storePrev_q;
    wire                            shiftRise;
    wire                            storeRise;

    // Shift stage, storage latch and output control.
    logic [sipo_pkg::WORD_WIDTH-1:0] shift_q;
    logic [sipo_pkg::WORD_WIDTH-1:0] shift_d;
    logic [sipo_pkg::WORD_WIDTH-1:0] latch_q;
    logic [sipo_pkg::WORD_WIDTH-1:0] latch_d;
    logic                            outEnN_q;
    logic                            updated_q;

    // Buffer between the capture strobe and the latch.
    wire                             bufValid;
    wire [sipo_pkg::WORD_WIDTH-1:0]  bufData;
    wire                             latchLoad;

    // One shift step: new bit into the first stage, every stage moves down.
    function automatic logic [sipo_pkg::WORD_WIDTH-1:0] nextShift(
        input logic [sipo_pkg::WORD_WIDTH-1:0] word,
        input logic                            bitIn
    );
        nextShift = {word[sipo_pkg::WORD_WIDTH-2:0], bitIn};
    endfunction

    // Rising edge of a synchronised pin against its level one clock earlier.
    function automatic logic risingEdge(
        input logic level,
        input logic prevLevel
    );
        risingEdge = level & ~prevLevel;
    endfunction

    assign pinRaw[sipo_pkg::PIN_SERIAL]      = serialIn;
    assign pinRaw[sipo_pkg::PIN_SHIFT_CLOCK] = shiftClock;
    assign pinRaw[sipo_pkg::PIN_SHIFT_CLEAR] = shiftClearN;
    assign pinRaw[sipo_pkg::PIN_STORE_CLOCK] = storageClock;
    assign pinRaw[sipo_pkg::PIN_OUT_ENABLE]  = outputEnableN;

    sipo_sync #(
        .WIDTH     (sipo_pkg::PIN_COUNT),
        .RESET_VAL (sipo_pkg::SYNC_RESET)
    ) u_sync (
        .clk     (clk),
        .srst    (srst),
        .pinIn   (pinRaw),
        .pinSync (pinSync)
    );

    assign serSync      = pinSync[sipo_pkg::PIN_SERIAL];
    assign shiftClkSync = pinSync[sipo_pkg::PIN_SHIFT_CLOCK];
    assign clearNSync   = pinSync[sipo_pkg::PIN_SHIFT_CLEAR];
    assign storeClkSync = pinSync[sipo_pkg::PIN_STORE_CLOCK];
    assign oeNSync      = pinSync[sipo_pkg::PIN_OUT_ENABLE];

    // Only rising edges act; falling edges are seen and ignored.
    assign shiftRise = risingEdge(shiftClkSync, shiftPrev_q);
    assign storeRise = risingEdge(storeClkSync, storePrev_q);

    // Clear acts on its level alone, whatever the shift clock does.
    assign shift_d = ~clearNSync ? sipo_pkg::SHIFT_RESET :
                     shiftRise   ? nextShift(shift_q, serSync) :
                     shift_q;

    // A capture is queued so that a stalled latch loses no word until two are waiting; a capture into the full buffer is dropped.
    sipo_buffer #(
        .WIDTH (sipo_pkg::WORD_WIDTH),
        .DEPTH (sipo_pkg::BUF_DEPTH)
    ) u_buffer (
        .clk      (clk),
        .srst     (srst),
        .inValid  (storeRise),
        .inReady  (captureReady),
        .inData   (shift_q),
        .outValid (bufValid),
        .outReady (latchReady),
        .outData  (bufData)
    );

    // The latch changes only on a buffered capture, never on a shift.
    assign latchLoad = bufValid & latchReady;
    assign latch_d   = latchLoad ? bufData : latch_q;

    // Previous levels reset high like the synchroniser, so leaving reset is never an edge.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shiftPrev_q <= sipo_pkg::EDGE_PREV_RESET;
            storePrev_q <= sipo_pkg::EDGE_PREV_RESET;
        end
        else
        begin
            shiftPrev_q <= shiftClkSync;
            storePrev_q <= storeClkSync;
        end
    end

    // Two independent stages: shift word and latched word.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shift_q <= sipo_pkg::SHIFT_RESET;
            latch_q <= sipo_pkg::LATCH_RESET;
        end
        else
        begin
            shift_q <= shift_d;
            latch_q <= latch_d;
        end
    end

    // The enable is registered like the data, so both reach the pins on one clock.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            outEnN_q  <= sipo_pkg::OE_N_RESET;
            updated_q <= 1'b0;
        end
        else
        begin
            outEnN_q  <= oeNSync;
            updated_q <= latchLoad;
        end
    end

    assign parallelOut    = latch_q;
    assign parallelOutEnN = outEnN_q;
    assign cascadeOut     = shift_q[sipo_pkg::LAST_STAGE];
    assign latchUpdated   = updated_q;

    // Checks on the shift stage.
    sequence shiftStep;
        shiftRise && clearNSync;
    endsequence

    sequence noShiftStep;
        !shiftRise && clearNSync;
    endsequence

    sequence shiftFall;
        shiftPrev_q && !shiftClkSync && clearNSync;
    endsequence

    AST_SHIFT_RISE: assert property (
        @(posedge clk) disable iff (srst)
        shiftStep |=> shift_q == nextShift($past(shift_q), $past(serSync)))
    else $error("Shift stage did not take the serial bit on a rise.");

    AST_SHIFT_HOLD: assert property (
        @(posedge clk) disable iff (srst)
        noShiftStep |=> $stable(shift_q))
    else $error("Shift stage changed without a rising shift clock.");

    AST_CLEAR_EMPTIES: assert property (
        @(posedge clk) disable iff (srst)
        !clearNSync |=> shift_q == sipo_pkg::SHIFT_RESET)
    else $error("Low clear did not empty the shift stage.");

    AST_CLEAR_KEEPS_LATCH: assert property (
        @(posedge clk) disable iff (srst)
        !clearNSync && !latchLoad |=> $stable(latch_q))
    else $error("Clear disturbed the storage latch.");

    AST_SHIFT_ONCE: assert property (
        @(posedge clk) disable iff (srst)
        shiftRise |=> !shiftRise)
    else $error("One shift clock rise was seen twice.");

    AST_SHIFT_FALL: assert property (
        @(posedge clk) disable iff (srst)
        shiftFall |=> $stable(shift_q))
    else $error("Shift stage changed on a falling shift clock.");

    AST_CLEAR_OVER_SHIFT: assert property (
        @(posedge clk) disable iff (srst)
        shiftRise && !clearNSync |=> shift_q == sipo_pkg::SHIFT_RESET)
    else $error("A shift got past a low clear.");

    // Checks on the storage latch.
    sequence captureIntoEmpty;
        storeRise && captureReady && !bufValid ##1 latchReady;
    endsequence

    sequence storeFall;
        storePrev_q && !storeClkSync && !bufValid;
    endsequence

    AST_CAPTURE: assert property (
        @(posedge clk) disable iff (srst)
        captureIntoEmpty |=> latch_q == $past(shift_q, 2) && latchUpdated)
    else $error("Storage rise did not reach the latch two cycles later.");

    AST_LATCH_HOLD: assert property (
        @(posedge clk) disable iff (srst)
        !latchLoad |=> $stable(latch_q) && !latchUpdated)
    else $error("Latch changed without a capture.");

    AST_SHIFT_KEEPS_OUTPUT: assert property (
        @(posedge clk) disable iff (srst)
        shiftStep ##0 !bufValid |=> $stable(parallelOut))
    else $error("Shifting disturbed the parallel outputs.");

    AST_STORE_ONCE: assert property (
        @(posedge clk) disable iff (srst)
        storeRise |=> !storeRise)
    else $error("One storage clock rise was seen twice.");

    AST_LATCH_FROM_BUFFER: assert property (
        @(posedge clk) disable iff (srst)
        latchLoad |=> latch_q == $past(bufData) && latchUpdated)
    else $error("Latch did not take the buffered word.");

    AST_STORE_FALL: assert property (
        @(posedge clk) disable iff (srst)
        storeFall |=> $stable(latch_q))
    else $error("Latch changed on a falling storage clock.");

    AST_STALL_HOLDS: assert property (
        @(posedge clk) disable iff (srst)
        !latchReady |=> $stable(parallelOut))
    else $error("Parallel outputs changed while the latch side stalled.");

    AST_FULL_WHILE_STALLED: assert property (
        @(posedge clk) disable iff (srst)
        !captureReady && !latchReady |=> !captureReady)
    else $error("Full buffer lost a word while stalled.");

    // Checks on the output pins.
    AST_OUTPUT_ENABLE: assert property (
        @(posedge clk) disable iff (srst)
        oeNSync |=> parallelOutEnN && ($stable(parallelOut) || $past(latchLoad)))
    else $error("Output enable did not follow the pin.");

    AST_OUTPUT_DRIVE: assert property (
        @(posedge clk) disable iff (srst)
        !oeNSync |=> !parallelOutEnN && parallelOut == latch_q)
    else $error("Parallel outputs not driven while enabled.");

    AST_CASCADE: assert property (
        @(posedge clk) disable iff (srst)
        shiftStep |=> cascadeOut == $past(shift_q[sipo_pkg::LAST_STAGE - 1]))
    else $error("Cascade output does not show the eighth stage.");

    AST_CASCADE_IGNORES_OE: assert property (
        @(posedge clk) disable iff (srst)
        noShiftStep ##0 $changed(oeNSync) |=> $stable(cascadeOut))
    else $error("Output enable disturbed the cascade output.");

    AST_OE_KEEPS_DATA: assert property (
        @(posedge clk) disable iff (srst)
        $changed(oeNSync) && !latchLoad |=> $stable(parallelOut))
    else $error("Output enable disturbed the latched word.");

endmodule

/* File: sipo_pkg.sv */
// Shared constants for the serial-in parallel-out latch.
package sipo_pkg;

    // Word width of the shift stage and of the storage latch.
    localparam int WORD_WIDTH = 8;

    // Depth of the buffer between the capture strobe and the storage latch.
    localparam int BUF_DEPTH = 2;

    // Bit positions of the host pins inside the synchroniser vector.
    localparam int PIN_COUNT        = 5;
    localparam int PIN_SERIAL       = 0;
    localparam int PIN_SHIFT_CLOCK  = 1;
    localparam int PIN_SHIFT_CLEAR  = 2;
    localparam int PIN_STORE_CLOCK  = 3;
    localparam int PIN_OUT_ENABLE   = 4;

    // Reset values.
    localparam logic [WORD_WIDTH-1:0] SHIFT_RESET = 8'h00;
    localparam logic [WORD_WIDTH-1:0] LATCH_RESET = 8'h00;
    localparam logic [PIN_COUNT-1:0]  SYNC_RESET  = 5'h1E;
    localparam logic                  OE_N_RESET  = 1'b1;
    localparam logic                  EDGE_PREV_RESET = 1'b1;

    // Position of the last shift stage, which feeds the cascade output.
    localparam int LAST_STAGE = WORD_WIDTH - 1;

endpackage

/* File: sipo_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/100ps

module sipo_sync #(
    parameter int                 WIDTH      = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL  = '0
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             srst,
    // Raw pins and their synchronised copies.
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage is read by the second stage only.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= pinIn;
            sync_q <= meta_q;
        end
    end

    assign pinSync = sync_q;

endmodule

/* File: sipo_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps

module sipo_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             srst,
    // Filling side.
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    wire              push;
    wire              pop;

    function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
        nextPtr = (p == PTR_LAST) ? '0 : p + PTR_W'(1);
    endfunction

    assign inReady  = (count_q != CNT_FULL);
    assign outValid = (count_q != '0);
    assign outData  = mem_q[rdPtr_q];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign count_d  = (push & ~pop) ? count_q + CNT_ONE :
                      (pop & ~push) ? count_q - CNT_ONE : count_q;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            wrPtr_q <= push ? nextPtr(wrPtr_q) : wrPtr_q;
            rdPtr_q <= pop ? nextPtr(rdPtr_q) : rdPtr_q;
            count_q <= count_d;
        end
    end

endmodule

/* File: host_model.sv */
// Behavioural host that drives the serial pins of the latch.
`timescale 1ns/100ps

module host_model (
    // Clock used to time the pin changes.
    input  wire logic clk,
    // Pins toward the latch.
    output logic      serialIn,
    output logic      shiftClock,
    output logic      shiftClearN,
    output logic      storageClock,
    output logic      outputEnableN
);
    localparam int HALF_LINK = 4;

    initial
    begin
        serialIn      = 1'b0;
        shiftClock    = 1'b0;
        shiftClearN   = 1'b1;
        storageClock  = 1'b0;
        outputEnableN = 1'b1;
    end

    // Sets one pin just after a falling edge, then holds it for half a link period.
    task automatic pinSet(input int which, input logic v);
        @(negedge clk);
        case (which)
            sipo_pkg::PIN_SERIAL:      serialIn = v;
            sipo_pkg::PIN_SHIFT_CLOCK: shiftClock = v;
            sipo_pkg::PIN_SHIFT_CLEAR: shiftClearN = v;
            sipo_pkg::PIN_STORE_CLOCK: storageClock = v;
            default:                   outputEnableN = v;
        endcase
        repeat (HALF_LINK - 1) @(negedge clk);
    endtask

    // Sends a byte first bit first, then leaves the data line showing a stale inverse.
    task automatic sendByte(input logic [7:0] word);
        for (int i = 7; i >= 0; i--)
        begin
            pinSet(sipo_pkg::PIN_SERIAL, word[i]);
            pinSet(sipo_pkg::PIN_SHIFT_CLOCK, 1'b1);
            pinSet(sipo_pkg::PIN_SHIFT_CLOCK, 1'b0);
        end
        pinSet(sipo_pkg::PIN_SERIAL, ~serialIn);
    endtask

    // One storage clock pulse, high then low.
    task automatic storeWord();
        pinSet(sipo_pkg::PIN_STORE_CLOCK, 1'b1);
        pinSet(sipo_pkg::PIN_STORE_CLOCK, 1'b0);
    endtask
endmodule

/* File: tb.sv */
// Self-checking testbench for the serial-in parallel-out latch.
`timescale 1ns/100ps

module tb;
    logic       clk;
    logic       srst;
    logic       latchReady;
    wire        serialIn;
    wire        shiftClock;
    wire        shiftClearN;
    wire        storageClock;
    wire        outputEnableN;
    logic [7:0] parallelOut;
    logic       parallelOutEnN;
    logic       cascadeOut;
    logic       captureReady;
    logic       latchUpdated;
    int         mismatches;
    int         total_checks;
    int         cycles;

    host_model host_model_inst (
        .clk(clk), .serialIn(serialIn), .shiftClock(shiftClock), .shiftClearN(shiftClearN),
        .storageClock(storageClock), .outputEnableN(outputEnableN)
    );

    serial_in_parallel_out_latch serial_in_parallel_out_latch_inst (
        .clk(clk), .srst(srst), .serialIn(serialIn), .shiftClock(shiftClock),
        .shiftClearN(shiftClearN), .storageClock(storageClock),
        .outputEnableN(outputEnableN), .parallelOut(parallelOut),
        .parallelOutEnN(parallelOutEnN), .cascadeOut(cascadeOut), .latchReady(latchReady),
        .captureReady(captureReady), .latchUpdated(latchUpdated)
    );

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Waits a bounded time for the latch-loaded pulse.
    task automatic waitUpdate();
        int n;
        n = 0;
        while (latchUpdated !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check({7'h00, latchUpdated}, 8'h01);
    endtask

    task automatic testReset();
        check(parallelOut, 8'h00);
        check({7'h00, parallelOutEnN}, 8'h01);
        check({7'h00, cascadeOut}, 8'h00);
        check({6'h00, captureReady, latchUpdated}, 8'h02);
    endtask

    task automatic testLoad();
        host_model_inst.pinSet(sipo_pkg::PIN_OUT_ENABLE, 1'b0);
        host_model_inst.sendByte(8'hA5);
        check({7'h00, cascadeOut}, 8'h01);
        host_model_inst.storeWord();
        check(parallelOut, 8'hA5);
        check({7'h00, parallelOutEnN}, 8'h00);
    endtask

    // Stage ends as 4C, then one rise gives 99; a shift on the fall would clear bit 7.
    task automatic testEdges();
        host_model_inst.sendByte(8'h4C);
        check(parallelOut, 8'hA5);
        check({7'h00, cascadeOut}, 8'h00);
        host_model_inst.pinSet(sipo_pkg::PIN_SHIFT_CLOCK, 1'b1);
        check({7'h00, cascadeOut}, 8'h01);
        host_model_inst.pinSet(sipo_pkg::PIN_SHIFT_CLOCK, 1'b0);
        check({7'h00, cascadeOut}, 8'h01);
        host_model_inst.storeWord();
        check(parallelOut, 8'h99);
    endtask

    task automatic testClear();
        host_model_inst.pinSet(sipo_pkg::PIN_SHIFT_CLEAR, 1'b0);
        check({7'h00, cascadeOut}, 8'h00);
        host_model_inst.sendByte(8'hFF);
        check({7'h00, cascadeOut}, 8'h00);
        check(parallelOut, 8'h99);
        host_model_inst.pinSet(sipo_pkg::PIN_SHIFT_CLEAR, 1'b1);
        host_model_inst.storeWord();
        check(parallelOut, 8'h00);
    endtask

    task automatic testEnable();
        host_model_inst.pinSet(sipo_pkg::PIN_OUT_ENABLE, 1'b1);
        check({7'h00, parallelOutEnN}, 8'h01);
        check({7'h00, cascadeOut}, 8'h00);
        host_model_inst.pinSet(sipo_pkg::PIN_OUT_ENABLE, 1'b0);
        check({7'h00, parallelOutEnN}, 8'h00);
    endtask

    // Two captures wait in the buffer while the latch side stalls; a third is dropped.
    task automatic testBuffer();
        @(negedge clk);
        latchReady = 1'b0;
        host_model_inst.sendByte(8'hC3);
        host_model_inst.storeWord();
        host_model_inst.sendByte(8'h81);
        host_model_inst.storeWord();
        check({7'h00, captureReady}, 8'h00);
        host_model_inst.sendByte(8'h7E);
        host_model_inst.storeWord();
        check(parallelOut, 8'h00);
        latchReady = ~latchReady;
        waitUpdate();
        check(parallelOut, 8'hC3);
        latchReady = ~latchReady;
        @(negedge clk);
        check({6'h00, captureReady, latchUpdated}, 8'h02);
        check(parallelOut, 8'hC3);
        latchReady = ~latchReady;
        @(negedge clk);
        check({7'h00, latchUpdated}, 8'h01);
        check(parallelOut, 8'h81);
        repeat (10) @(negedge clk);
        check({6'h00, captureReady, latchUpdated}, 8'h02);
        check(parallelOut, 8'h81);
    endtask

    // A reset in mid-run empties both stages and the buffer, then a load works again.
    task automatic testMidReset();
        host_model_inst.pinSet(sipo_pkg::PIN_SHIFT_CLOCK, 1'b1);
        host_model_inst.pinSet(sipo_pkg::PIN_SHIFT_CLOCK, 1'b0);
        check({7'h00, cascadeOut}, 8'h01);
        srst = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        check(parallelOut, 8'h00);
        check({7'h00, cascadeOut}, 8'h00);
        check({6'h00, captureReady, latchUpdated}, 8'h02);
        check({7'h00, parallelOutEnN}, 8'h01);
        repeat (3) @(negedge clk);
        check({7'h00, parallelOutEnN}, 8'h00);
        host_model_inst.sendByte(8'h5A);
        host_model_inst.storeWord();
        check(parallelOut, 8'h5A);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            $display("Error at %0t: cycles %h limit %h", $time, cycles, 5000);
            end_of_test();
        end
    end

    initial
    begin
        srst = 1'b1;
        latchReady = 1'b1;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        testReset();
        testLoad();
        testEdges();
        testClear();
        testEnable();
        testBuffer();
        testMidReset();
        end_of_test();
    end
endmodule
